// file: rtl/otpc_pkg.sv
// Constants and carrier types for oscillator trim and RAM power control
package otpc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] STAT_IDX = 32'h50000014;
  localparam logic [31:0] TRIM_IDX = 32'h50000016;
  localparam logic [31:0] RAM_IDX  = 32'h50000018;
  localparam logic [31:0] RC_IDX   = 32'h50000020;
  localparam logic [31:0] XK_IDX   = 32'h50000022;
  localparam int          DEC_W    = 12;

  // Crystal trim control fields
  localparam int SETTLE_LSB = 8;
  localparam int TSEL_LSB   = 6;
  localparam int CNTN_LSB   = 0;
  localparam logic [15:0] TRIM_RST  = 16'h3f22;
  localparam logic [15:0] TRIM_MASK = 16'h3fff;
  localparam logic [1:0]  TSEL_CNT  = 2'h0;
  localparam logic [1:0]  TSEL_AMP  = 2'h1;
  localparam logic [1:0]  TSEL_OFF  = 2'h2;
  localparam logic [1:0]  TSEL_TWO  = 2'h3;

  // RAM bank power fields, two bits per bank
  localparam int          NBANK    = 3;
  localparam logic [15:0] RAM_RST  = 16'h0000;
  localparam logic [15:0] RAM_MASK = 16'h003f;

  // Slow RC control
  localparam int          RC_OFF_BIT  = 0;
  localparam int          RC_TRIM_LSB = 1;
  localparam logic [15:0] RC_RST      = 16'h000e;
  localparam logic [15:0] RC_MASK     = 16'h001f;

  // Slow crystal control
  localparam int          XK_ON_BIT   = 0;
  localparam int          XK_RES_LSB  = 1;
  localparam int          XK_CUR_LSB  = 3;
  localparam int          XK_AREG_BIT = 7;
  localparam logic [15:0] XK_RST      = 16'h002e;
  localparam logic [15:0] XK_MASK     = 16'h00ff;

  // Status bits
  localparam int STAT_SETTLED_BIT = 7;
  localparam int STAT_TRIMRDY_BIT = 6;

  // Timing: 32 us ramp timeout at a 4 ns clock, rounded down
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          TIMEOUT_US    = 32;
  localparam logic [13:0] TIMEOUT_CYC   =
    14'(TIMEOUT_US * 1000000 / CLK_PERIOD_PS);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OTPC_TRIM_START = 3'b001,
    OTPC_TRIM_RAMP  = 3'b010,
    OTPC_TRIM_FINAL = 3'b100
  } otpc_trim_t;

  typedef struct packed {
    logic access_en;
    logic retain;
    logic off;
  } otpc_bank_t;

  typedef struct packed {
    logic [3:0] rc_trim;
    logic       rc_off;
    logic       xk_ampreg_off;
    logic [3:0] xk_bias_cur;
    logic [1:0] xk_bias_res;
    logic       xk_on;
  } otpc_osc_t;

endpackage

// file: rtl/otpc_top.sv
// Oscillator trim sequencing, settle counter, RAM bank power and slow osc
`timescale 1ns/1ps
module otpc_top #(
  parameter logic [13:0] TIMEOUT_CYC = otpc_pkg::TIMEOUT_CYC
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [31:0]           araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  xtal_clk_in,
  input  wire logic                  xtal_amp_ramping,
  input  wire logic                  xtal_running,
  input  wire logic                  deep_power_mode,
  output otpc_pkg::otpc_trim_t       trim_sel_q,
  output logic                       fast_crystal_settled_flag,
  output otpc_pkg::otpc_bank_t [2:0] bank_q,
  output otpc_pkg::otpc_osc_t        osc_q
);

  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [31:0] idx);
    reg_hit = addr[otpc_pkg::DEC_W-1:0] ==
              {idx[otpc_pkg::DEC_W-3:0], 2'b00};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~m) | (data[15:0] & m);
  endfunction

  // Deep modes keep only even codes; odd codes lose their contents
  function automatic otpc_pkg::otpc_bank_t bank_dec(input logic [1:0] c,
                                                    input logic deep);
    otpc_pkg::otpc_bank_t b;
    b = '0;
    if (deep)
    begin
      b.retain = ~c[0];
      b.off    = c[0];
    end
    else
    begin
      b.access_en = ~c[1];
      b.retain    = (c == 2'h2);
      b.off       = (c == 2'h3);
    end
    bank_dec = b;
  endfunction

  // Register file and bus slave
  logic [15:0] trim_q;
  logic [15:0] ram_q;
  logic [15:0] rc_q;
  logic [15:0] xk_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        do_wr;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] stat_w;

  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready  = ~w_have_q & ~bvalid_q;
  assign do_wr   = aw_have_q & w_have_q & ~bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  assign wr_hit = reg_hit(awaddr_q, otpc_pkg::TRIM_IDX) |
                  reg_hit(awaddr_q, otpc_pkg::RAM_IDX)  |
                  reg_hit(awaddr_q, otpc_pkg::RC_IDX)   |
                  reg_hit(awaddr_q, otpc_pkg::XK_IDX)   |
                  reg_hit(awaddr_q, otpc_pkg::STAT_IDX);
  assign rd_hit = reg_hit(araddr, otpc_pkg::TRIM_IDX) |
                  reg_hit(araddr, otpc_pkg::RAM_IDX)  |
                  reg_hit(araddr, otpc_pkg::RC_IDX)   |
                  reg_hit(araddr, otpc_pkg::XK_IDX)   |
                  reg_hit(araddr, otpc_pkg::STAT_IDX);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_have_q <= 1'b1;
      awaddr_q  <= awaddr;
    end
    else if (do_wr)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (wvalid && wready)
    begin
      w_have_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end
    else if (do_wr)
      w_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= otpc_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? otpc_pkg::RESP_OKAY : otpc_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // Reserved bits are masked on write so they always read as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_q <= otpc_pkg::TRIM_RST;
      ram_q  <= otpc_pkg::RAM_RST;
      rc_q   <= otpc_pkg::RC_RST;
      xk_q   <= otpc_pkg::XK_RST;
    end
    else if (do_wr)
    begin
      if (reg_hit(awaddr_q, otpc_pkg::TRIM_IDX))
        trim_q <= merge(trim_q, wdata_q, wstrb_q, otpc_pkg::TRIM_MASK);
      if (reg_hit(awaddr_q, otpc_pkg::RAM_IDX))
        ram_q <= merge(ram_q, wdata_q, wstrb_q, otpc_pkg::RAM_MASK);
      if (reg_hit(awaddr_q, otpc_pkg::RC_IDX))
        rc_q <= merge(rc_q, wdata_q, wstrb_q, otpc_pkg::RC_MASK);
      if (reg_hit(awaddr_q, otpc_pkg::XK_IDX))
        xk_q <= merge(xk_q, wdata_q, wstrb_q, otpc_pkg::XK_MASK);
    end
  end

  always_comb
  begin
    stat_w = '0;
    stat_w[otpc_pkg::STAT_SETTLED_BIT] = fast_crystal_settled_flag;
    stat_w[otpc_pkg::STAT_TRIMRDY_BIT] =
      (trim_sel_q == otpc_pkg::OTPC_TRIM_FINAL);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= otpc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? otpc_pkg::RESP_OKAY : otpc_pkg::RESP_SLVERR;
      if (reg_hit(araddr, otpc_pkg::TRIM_IDX))
        rdata_q <= {16'h0000, trim_q};
      else if (reg_hit(araddr, otpc_pkg::RAM_IDX))
        rdata_q <= {16'h0000, ram_q};
      else if (reg_hit(araddr, otpc_pkg::RC_IDX))
        rdata_q <= {16'h0000, rc_q};
      else if (reg_hit(araddr, otpc_pkg::XK_IDX))
        rdata_q <= {16'h0000, xk_q};
      else if (reg_hit(araddr, otpc_pkg::STAT_IDX))
        rdata_q <= {16'h0000, stat_w};
      else
        rdata_q <= '0;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // Pin synchronisers: crystal clock, amplitude ramp, crystal running
  logic [2:0] pin_in;
  logic [2:0] pin_f_q;
  assign pin_in = {xtal_running, xtal_amp_ramping, xtal_clk_in};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    logic [2:0] s_q;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        s_q <= '0;
      else
        s_q <= {s_q[1:0], pin_in[i]};
    end
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pin_f_q[i] <= 1'b0;
      else if (s_q[1] == s_q[2])
        pin_f_q[i] <= s_q[2];
    end
  end

  logic xclk_prev_q;
  logic xclk_rise;
  logic run_f;
  logic amp_f;
  assign run_f     = pin_f_q[2];
  assign amp_f     = pin_f_q[1];
  assign xclk_rise = pin_f_q[0] & ~xclk_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xclk_prev_q <= 1'b0;
    else
      xclk_prev_q <= pin_f_q[0];
  end

  // Crystal cycle counter saturates so a long run never wraps back
  logic [11:0] crystal_cycle_counter_q;
  logic [11:0] settle_thr;
  logic [11:0] switch_thr;
  logic [1:0]  tsel;
  assign settle_thr = {trim_q[otpc_pkg::SETTLE_LSB +: 6], 6'h00};
  assign switch_thr = {1'b0, trim_q[otpc_pkg::CNTN_LSB +: 6], 5'h00};
  assign tsel       = trim_q[otpc_pkg::TSEL_LSB +: 2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_f)
      crystal_cycle_counter_q <= '0;
    else if (xclk_rise && crystal_cycle_counter_q != 12'hfff)
      crystal_cycle_counter_q <= crystal_cycle_counter_q + 12'h001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_f)
      fast_crystal_settled_flag <= 1'b0;
    else if (crystal_cycle_counter_q >= settle_thr)
      fast_crystal_settled_flag <= 1'b1;
  end

  logic [13:0] timer_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_f || trim_sel_q != otpc_pkg::OTPC_TRIM_START)
      timer_q <= '0;
    else if (timer_q != TIMEOUT_CYC)
      timer_q <= timer_q + 14'h0001;
  end

  // Trim sequencer; reset shows final trim, matching the ready bit default
  otpc_pkg::otpc_trim_t trim_d;
  always_comb
  begin
    trim_d = trim_sel_q;
    if (tsel == otpc_pkg::TSEL_OFF)
      trim_d = otpc_pkg::OTPC_TRIM_FINAL;
    else if (!run_f)
      trim_d = otpc_pkg::OTPC_TRIM_START;
    else
    begin
      unique case (trim_sel_q)
        otpc_pkg::OTPC_TRIM_START:
        begin
          if (tsel == otpc_pkg::TSEL_CNT &&
              crystal_cycle_counter_q >= switch_thr)
            trim_d = otpc_pkg::OTPC_TRIM_FINAL;
          else if (tsel == otpc_pkg::TSEL_AMP && amp_f)
            trim_d = otpc_pkg::OTPC_TRIM_FINAL;
          else if (tsel == otpc_pkg::TSEL_TWO && timer_q == TIMEOUT_CYC)
            trim_d = otpc_pkg::OTPC_TRIM_RAMP;
        end
        otpc_pkg::OTPC_TRIM_RAMP:
        begin
          if (amp_f)
            trim_d = otpc_pkg::OTPC_TRIM_FINAL;
        end
        otpc_pkg::OTPC_TRIM_FINAL:
          trim_d = otpc_pkg::OTPC_TRIM_FINAL;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_sel_q <= otpc_pkg::OTPC_TRIM_FINAL;
    else
      trim_sel_q <= trim_d;
  end

  // Bank controls; software must only retarget an idle bank
  for (genvar b = 0; b < otpc_pkg::NBANK; b++)
  begin : g_bank
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        bank_q[b] <= bank_dec(2'h0, 1'b0);
      else
        bank_q[b] <= bank_dec(ram_q[2*b +: 2], deep_power_mode);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_q <= '0;
    else
    begin
      osc_q.rc_trim       <= rc_q[otpc_pkg::RC_TRIM_LSB +: 4];
      osc_q.rc_off        <= rc_q[otpc_pkg::RC_OFF_BIT];
      osc_q.xk_ampreg_off <= xk_q[otpc_pkg::XK_AREG_BIT];
      osc_q.xk_bias_cur   <= xk_q[otpc_pkg::XK_CUR_LSB +: 4];
      osc_q.xk_bias_res   <= xk_q[otpc_pkg::XK_RES_LSB +: 2];
      osc_q.xk_on         <= xk_q[otpc_pkg::XK_ON_BIT];
    end
  end

  // Checks
  sequence s_trim_write;
    do_wr && reg_hit(awaddr_q, otpc_pkg::TRIM_IDX) && (wstrb_q[1:0] == 2'h3);
  endsequence

  sequence s_rc_off_write;
    do_wr && reg_hit(awaddr_q, otpc_pkg::RC_IDX) && wstrb_q[0] &&
    wdata_q[otpc_pkg::RC_OFF_BIT];
  endsequence

  a_settle_flag_set: assert property (@(posedge aclk)
    disable iff (!aresetn)
    run_f && $stable(run_f) && crystal_cycle_counter_q >= settle_thr
    |=> fast_crystal_settled_flag)
    else $error("settled flag missed threshold");

  a_restart_clears: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !run_f |=> crystal_cycle_counter_q == 12'h000 &&
    !fast_crystal_settled_flag)
    else $error("restart did not clear counter");

  a_count_mode_switch: assert property (@(posedge aclk)
    disable iff (!aresetn)
    run_f && tsel == otpc_pkg::TSEL_CNT &&
    trim_sel_q == otpc_pkg::OTPC_TRIM_START &&
    crystal_cycle_counter_q >= switch_thr
    |=> trim_sel_q == otpc_pkg::OTPC_TRIM_FINAL)
    else $error("count mode failed to switch");

  a_amp_mode_switch: assert property (@(posedge aclk)
    disable iff (!aresetn)
    run_f && tsel == otpc_pkg::TSEL_AMP && amp_f
    |=> trim_sel_q == otpc_pkg::OTPC_TRIM_FINAL)
    else $error("amplitude mode failed to switch");

  a_static_final: assert property (@(posedge aclk)
    disable iff (!aresetn)
    tsel == otpc_pkg::TSEL_OFF |=> trim_sel_q == otpc_pkg::OTPC_TRIM_FINAL)
    else $error("static mode left final trim");

  a_ramp_timeout: assert property (@(posedge aclk)
    disable iff (!aresetn)
    run_f && tsel == otpc_pkg::TSEL_TWO && !amp_f &&
    trim_sel_q == otpc_pkg::OTPC_TRIM_START && timer_q == TIMEOUT_CYC
    |=> trim_sel_q == otpc_pkg::OTPC_TRIM_RAMP)
    else $error("ramp stage missed timeout");

  a_bank_code_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (ram_q[1:0] == 2'h3 || (deep_power_mode && ram_q[0]))
    |=> bank_q[0].off && !bank_q[0].access_en)
    else $error("bank not switched off");

  a_deep_retain: assert property (@(posedge aclk)
    disable iff (!aresetn)
    deep_power_mode && !ram_q[2] |=> bank_q[1].retain && !bank_q[1].off)
    else $error("deep bank not retained");

  a_trim_write_effect: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_trim_write |=> trim_q == ($past(wdata_q[15:0]) & otpc_pkg::TRIM_MASK))
    else $error("trim write not applied");

  a_rc_stop_fast: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_rc_off_write |=> ##1 osc_q.rc_off)
    else $error("slow rc did not stop");

endmodule

// file: verif/otpc_top_test.sv
// Self-checking bench for oscillator trim and RAM power control
`timescale 1ns/1ps
module otpc_top_test;
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } otpc_row_t;

  logic                       aclk, aresetn, awvalid, awready, wvalid;
  logic                       wready, bvalid, bready, arvalid, arready;
  logic                       rvalid, rready, xclk, amp, running, deep;
  logic                       ramp_go, settled;
  logic [31:0]                awaddr, wdata, araddr, rdata, rd_d;
  logic [3:0]                 wstrb;
  logic [1:0]                 bresp, rresp, rd_r;
  otpc_pkg::otpc_trim_t       trim_sel;
  otpc_pkg::otpc_bank_t [2:0] bank;
  otpc_pkg::otpc_bank_t       e;
  otpc_pkg::otpc_osc_t        osc;
  int                         err_total, cmp_count, cyc, t0;

  otpc_row_t rows [9] = '{
    '{1'b0, 32'h58, 32'h0, 32'h3f22},
    '{1'b0, 32'h60, 32'h0, 32'h0},
    '{1'b0, 32'h80, 32'h0, 32'he},
    '{1'b0, 32'h88, 32'h0, 32'h2e},
    '{1'b1, 32'h80, 32'hffff, 32'h1f},
    '{1'b1, 32'h88, 32'hffff, 32'hff},
    '{1'b1, 32'h88, 32'h0, 32'h0},
    '{1'b1, 32'h60, 32'hffff, 32'h3f},
    '{1'b1, 32'h50000058, 32'hffff1234, 32'h1234}};

  otpc_top #(.TIMEOUT_CYC(14'h14)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .xtal_clk_in(xclk),
    .xtal_amp_ramping(amp), .xtal_running(running),
    .deep_power_mode(deep), .trim_sel_q(trim_sel),
    .fast_crystal_settled_flag(settled), .bank_q(bank), .osc_q(osc));

  otpc_xtal_model i_xtal (
    .aclk(aclk), .run(running), .ramp_go(ramp_go), .xclk(xclk),
    .amp_ramping(amp));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs about 1200 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge aclk);
      if (!aw_d && awready)
      begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready)
      begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do
      @(posedge aclk);
    while (bvalid !== 1'b1);
    rd_r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic arm(input logic [1:0] m, input logic [5:0] sn,
                     input logic [5:0] cn);
    running <= 1'b0;
    ramp_go <= 1'b0;
    wr(32'h58, {18'h0, sn, m, cn});
    repeat (4) @(posedge aclk);
    running <= 1'b1;
    t0 = cyc;
  endtask

  task automatic wsel(input otpc_pkg::otpc_trim_t t, input int mx);
    int k;
    k = 0;
    while (trim_sel !== t && k < mx)
    begin
      @(posedge aclk);
      k++;
    end
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    {running, deep, ramp_go} = 3'h0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    {err_total, cmp_count, cyc, t0} = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
      begin
        wr(rows[i].addr, rows[i].wdat);
        chk("write resp", otpc_pkg::RESP_OKAY, rd_r);
      end
      rd(rows[i].addr);
      chk("reg read", rows[i].exp, rd_d);
      chk("read resp", otpc_pkg::RESP_OKAY, rd_r);
    end
    // Only the upper byte lane is enabled, so the low byte must survive
    wstrb <= 4'h2;
    wr(32'h58, 32'h0500);
    wstrb <= 4'hf;
    rd(32'h58);
    chk("strobe merge", 32'h0534, rd_d);
    $display("test registers end");
    rd(32'ha4);
    chk("unmapped resp", otpc_pkg::RESP_SLVERR, rd_r);
    chk("unmapped data", 32'h0, rd_d);
    wr(32'ha4, 32'hffff);
    chk("unmapped wresp", otpc_pkg::RESP_SLVERR, rd_r);
    wr(32'h50, 32'hffff);
    chk("status wresp", otpc_pkg::RESP_OKAY, rd_r);
    for (int i = 0; i < 8; i++)
    begin
      deep <= i[2];
      wr(32'h60, {26'h0, i[1:0], i[1:0], i[1:0]});
      repeat (2) @(posedge aclk);
      e.access_en = !i[2] && !i[1];
      e.retain = i[2] ? !i[0] : (i[1:0] == 2'h2);
      e.off = i[2] ? i[0] : (i[1:0] == 2'h3);
      chk("bank state", {3{e}}, bank);
    end
    deep <= 1'b0;
    wr(32'h80, 32'h1);
    wr(32'h88, 32'h8b);
    repeat (2) @(posedge aclk);
    chk("osc out", {4'h0, 1'b1, 1'b1, 4'h1, 2'h1, 1'b1}, osc);
    $display("test banks and osc end");
    arm(2'h2, 6'h3f, 6'h01);
    chk("fixed final", otpc_pkg::OTPC_TRIM_FINAL, trim_sel);
    repeat (300) @(posedge aclk);
    chk("fixed final run", otpc_pkg::OTPC_TRIM_FINAL, trim_sel);
    arm(2'h0, 6'h01, 6'h01);
    repeat (20) @(posedge aclk);
    chk("count start", otpc_pkg::OTPC_TRIM_START, trim_sel);
    wsel(otpc_pkg::OTPC_TRIM_FINAL, 400);
    chk("count switch", 1, (cyc - t0) inside {[245:275]});
    while (settled !== 1'b1 && cyc - t0 < 700)
      @(posedge aclk);
    chk("settle time", 1, (cyc - t0) inside {[490:540]});
    rd(32'h50);
    chk("status settled", 1'b1, rd_d[7]);
    chk("status trim ready", 1'b1, rd_d[6]);
    running <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("restart flag", 1'b0, settled);
    chk("restart sel", otpc_pkg::OTPC_TRIM_START, trim_sel);
    $display("test count and settle end");
    arm(2'h1, 6'h3f, 6'h3f);
    repeat (100) @(posedge aclk);
    chk("amp start", otpc_pkg::OTPC_TRIM_START, trim_sel);
    ramp_go <= 1'b1;
    wsel(otpc_pkg::OTPC_TRIM_FINAL, 20);
    chk("amp final", otpc_pkg::OTPC_TRIM_FINAL, trim_sel);
    arm(2'h3, 6'h3f, 6'h3f);
    wsel(otpc_pkg::OTPC_TRIM_RAMP, 100);
    chk("timeout time", 1, (cyc - t0) inside {[18:32]});
    repeat (50) @(posedge aclk);
    chk("ramp hold", otpc_pkg::OTPC_TRIM_RAMP, trim_sel);
    ramp_go <= 1'b1;
    wsel(otpc_pkg::OTPC_TRIM_FINAL, 20);
    chk("two stage final", otpc_pkg::OTPC_TRIM_FINAL, trim_sel);
    $display("test trim modes end");
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("reset settled", 1'b0, settled);
    chk("reset rc trim", 4'h7, osc.rc_trim);
    rd(32'h58);
    chk("reset trim reg", 32'h3f22, rd_d);
    $display("test second reset end");
    end_of_test();
  end
endmodule

// file: verif/otpc_xtal_model.sv
// Behavioural fast crystal: divided clock and amplitude indication
`timescale 1ns/1ps
module otpc_xtal_model (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic ramp_go,
  output logic      xclk,
  output logic      amp_ramping
);
  logic [1:0] div_q  = 2'h0;
  logic       xclk_q = 1'b0;

  assign xclk = xclk_q;

  // Each level lasts four cycles, above the two the pin filter needs
  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      div_q  <= 2'h0;
      xclk_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
        xclk_q <= !xclk_q;
    end
  end

  // Amplitude can only ramp while the crystal oscillates
  assign amp_ramping = run & ramp_go;
endmodule
